// ==== dlie_pkg.sv ====
// Constants for the data link event interrupt enable block
// How it works
// (RULE_01) Bit 6 enables transmit start interrupt
// (RULE_02) Bit 5 enables receive start interrupt
// (RULE_03) Bit 4 enables transmit done interrupt
// (RULE_04) Bit 3 enables receive done interrupt
// (RULE_05) Bit 2 enables check sequence error interrupt
// (RULE_06) Bit 1 enables abort (seven ones) interrupt
// (RULE_07) Bit 0 enables idle flag interrupt
// (RULE_08) Enables read/write, reset to all cleared
// (RULE_09) Status flags latch until a status read or a write of ones to the clear offset clears them
// (RULE_10) Idle with receive done means whole message
// (RULE_11) Irq while enabled flag set; bit 7 zero
package dlie_pkg;
    localparam logic [15:0] enable_offset  = 16'h0b07;
    localparam logic [15:0] status_offset  = 16'h0b06;
    localparam logic [15:0] clear_offset   = 16'h0b10;
    localparam logic [15:0] whole_offset   = 16'h0b11;
    localparam int          event_count    = 7;
    localparam logic [6:0]  enable_reset   = 7'h00;
    localparam logic [6:0]  status_reset   = 7'h00;
    localparam int          bit_tx_begin   = 6;
    localparam int          bit_rx_begin   = 5;
    localparam int          bit_tx_done    = 4;
    localparam int          bit_rx_done    = 3;
    localparam int          bit_check_err  = 2;
    localparam int          bit_abort      = 1;
    localparam int          bit_idle       = 0;
    localparam logic [7:0]  flag_octet     = 8'h7e;
    localparam int          abort_ones     = 7;
endpackage : dlie_pkg

// ==== dlie_top.sv ====
// Interrupt enable, sticky status and request for one data link controller pair
//
// Chosen here: the strobed register port.
`timescale 1ns/100ps
module dlie_top (
    // Clock and reset
    input  wire logic        clock,
    input  wire logic        rstn,
    // Register port
    input  wire logic [15:0] addr,
    input  wire logic [7:0]  wdata,
    input  wire logic        wr,
    input  wire logic        rd,
    output logic      [7:0]  rdata,
    // Controller events, one-cycle pulses
    input  wire logic        tx_msg_begin,
    input  wire logic        rx_msg_begin,
    input  wire logic        tx_msg_done,
    input  wire logic        rx_msg_done,
    input  wire logic        check_seq_error,
    input  wire logic        rx_abort_seen,
    input  wire logic        rx_flag_idle,
    // Interrupt and message indication
    output logic             irq,
    output logic             rx_whole_msg
);
    logic       rst_meta;
    logic       rst_sync;
    logic [6:0] data_link_event_irq_enable;
    logic [6:0] status;
    logic [6:0] events;
    logic [6:0] next_status;
    logic       wr_enable;
    logic       rd_status;
    logic       wr_clear;
    logic       whole_sticky;

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            rst_meta <= 1'b0;
            rst_sync <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_sync <= rst_meta;
        end
    end

    assign events[dlie_pkg::bit_tx_begin]  = tx_msg_begin;    // [RULE_01]
    assign events[dlie_pkg::bit_rx_begin]  = rx_msg_begin;    // [RULE_02]
    assign events[dlie_pkg::bit_tx_done]   = tx_msg_done;     // [RULE_03]
    assign events[dlie_pkg::bit_rx_done]   = rx_msg_done;     // [RULE_04]
    assign events[dlie_pkg::bit_check_err] = check_seq_error; // [RULE_05]
    assign events[dlie_pkg::bit_abort]     = rx_abort_seen;   // [RULE_06]
    assign events[dlie_pkg::bit_idle]      = rx_flag_idle;    // [RULE_07]

    assign wr_enable = wr && (addr == dlie_pkg::enable_offset);
    assign rd_status = rd && (addr == dlie_pkg::status_offset);
    assign wr_clear  = wr && (addr == dlie_pkg::clear_offset);

    always_ff @(posedge clock or negedge rst_sync) begin
        if (!rst_sync) begin
            data_link_event_irq_enable <= dlie_pkg::enable_reset; // [RULE_08]
        end else if (wr_enable) begin
            data_link_event_irq_enable <= wdata[6:0]; // [RULE_08] [RULE_11]
        end
    end

    // A new event in the clearing cycle survives the clear
    generate
        for (genvar i = 0; i < dlie_pkg::event_count; i++) begin : g_flag
            always_comb begin
                next_status[i] = status[i];
                if (rd_status || (wr_clear && wdata[i])) begin
                    next_status[i] = 1'b0; // [RULE_09]
                end
                if (events[i]) begin
                    next_status[i] = 1'b1;
                end
            end
        end
    endgenerate

    always_ff @(posedge clock or negedge rst_sync) begin
        if (!rst_sync) begin
            status <= dlie_pkg::status_reset;
        end else begin
            status <= next_status; // [RULE_09]
        end
    end

    // Registered from next values so irq tracks status in the same cycle
    always_ff @(posedge clock or negedge rst_sync) begin
        if (!rst_sync) begin
            irq <= 1'b0;
        end else begin
            irq <= |(next_status & (wr_enable ? wdata[6:0] : data_link_event_irq_enable)); // [RULE_11]
        end
    end

    always_ff @(posedge clock or negedge rst_sync) begin
        if (!rst_sync) begin
            whole_sticky <= 1'b0;
        end else if (rx_flag_idle && rx_msg_done) begin
            whole_sticky <= 1'b1; // [RULE_10]
        end else if (rd && (addr == dlie_pkg::whole_offset)) begin
            whole_sticky <= 1'b0;
        end
    end

    always_ff @(posedge clock or negedge rst_sync) begin
        if (!rst_sync) begin
            rx_whole_msg <= 1'b0;
        end else begin
            rx_whole_msg <= rx_flag_idle && rx_msg_done; // [RULE_10]
        end
    end

    always_ff @(posedge clock or negedge rst_sync) begin
        if (!rst_sync) begin
            rdata <= 8'h00;
        end else if (rd) begin
            unique case (addr)
                dlie_pkg::enable_offset: rdata <= {1'b0, data_link_event_irq_enable}; // [RULE_11]
                dlie_pkg::status_offset: rdata <= {1'b0, status};
                dlie_pkg::whole_offset:  rdata <= {7'h00, whole_sticky};
                default:                 rdata <= 8'h00;
            endcase
        end else begin
            rdata <= 8'h00;
        end
    end

    enable_reset_a: assert property (@(posedge clock) $rose(rst_sync) |->
        data_link_event_irq_enable == 7'h00) else $error("enables not cleared"); // [RULE_08]
    enable_write_a: assert property (@(posedge clock) disable iff (!rst_sync)
        wr_enable |=> data_link_event_irq_enable == $past(wdata[6:0]))
        else $error("enable write lost"); // [RULE_08]
    tx_begin_a: assert property (@(posedge clock) disable iff (!rst_sync)
        tx_msg_begin && data_link_event_irq_enable[6] && !wr_enable |=> irq)
        else $error("tx begin no irq"); // [RULE_01]
    rx_begin_a: assert property (@(posedge clock) disable iff (!rst_sync)
        rx_msg_begin && data_link_event_irq_enable[5] && !wr_enable |=> irq)
        else $error("rx begin no irq"); // [RULE_02]
    tx_done_a: assert property (@(posedge clock) disable iff (!rst_sync)
        tx_msg_done && data_link_event_irq_enable[4] && !wr_enable |=> irq)
        else $error("tx done no irq"); // [RULE_03]
    rx_done_a: assert property (@(posedge clock) disable iff (!rst_sync)
        rx_msg_done && data_link_event_irq_enable[3] && !wr_enable |=> irq)
        else $error("rx done no irq"); // [RULE_04]
    check_err_a: assert property (@(posedge clock) disable iff (!rst_sync)
        check_seq_error && data_link_event_irq_enable[2] && !wr_enable |=> irq)
        else $error("check error no irq"); // [RULE_05]
    abort_irq_a: assert property (@(posedge clock) disable iff (!rst_sync)
        rx_abort_seen && data_link_event_irq_enable[1] && !wr_enable |=> irq)
        else $error("abort no irq"); // [RULE_06]
    idle_irq_a: assert property (@(posedge clock) disable iff (!rst_sync)
        rx_flag_idle && data_link_event_irq_enable[0] && !wr_enable |=> irq)
        else $error("idle no irq"); // [RULE_07]
    read_clear_a: assert property (@(posedge clock) disable iff (!rst_sync)
        rd_status && !(|events) |=> status == 7'h00)
        else $error("read did not clear"); // [RULE_09]
    flag_hold_a: assert property (@(posedge clock) disable iff (!rst_sync)
        status[3] && !rd_status && !wr_clear |=> status[3])
        else $error("flag dropped"); // [RULE_09]
    whole_msg_a: assert property (@(posedge clock) disable iff (!rst_sync)
        rx_flag_idle && rx_msg_done |=> rx_whole_msg && whole_sticky)
        else $error("whole message missed"); // [RULE_10]
    irq_match_a: assert property (@(posedge clock) disable iff (!rst_sync)
        irq == |(status & data_link_event_irq_enable))
        else $error("irq mismatch"); // [RULE_11]
    bit7_zero_a: assert property (@(posedge clock) disable iff (!rst_sync)
        $past(rd) && $past(addr) == dlie_pkg::enable_offset |-> !rdata[7])
        else $error("bit 7 not zero"); // [RULE_11]

    // Each event latches its own status bit
    tx_begin_set_a: assert property (@(posedge clock) disable iff (!rst_sync) // [RULE_01]
        events[dlie_pkg::bit_tx_begin]
        |=> status[dlie_pkg::bit_tx_begin])
        else $error("tx begin not latched");

    rx_begin_set_a: assert property (@(posedge clock) disable iff (!rst_sync) // [RULE_02]
        events[dlie_pkg::bit_rx_begin]
        |=> status[dlie_pkg::bit_rx_begin])
        else $error("rx begin not latched");

    tx_done_set_a: assert property (@(posedge clock) disable iff (!rst_sync) // [RULE_03]
        events[dlie_pkg::bit_tx_done]
        |=> status[dlie_pkg::bit_tx_done])
        else $error("tx done not latched");

    rx_done_set_a: assert property (@(posedge clock) disable iff (!rst_sync) // [RULE_04]
        events[dlie_pkg::bit_rx_done]
        |=> status[dlie_pkg::bit_rx_done])
        else $error("rx done not latched");

    check_err_set_a: assert property (@(posedge clock) disable iff (!rst_sync) // [RULE_05]
        events[dlie_pkg::bit_check_err]
        |=> status[dlie_pkg::bit_check_err])
        else $error("check error not latched");

    abort_set_a: assert property (@(posedge clock) disable iff (!rst_sync) // [RULE_06]
        events[dlie_pkg::bit_abort]
        |=> status[dlie_pkg::bit_abort])
        else $error("abort not latched");

    idle_set_a: assert property (@(posedge clock) disable iff (!rst_sync) // [RULE_07]
        events[dlie_pkg::bit_idle]
        |=> status[dlie_pkg::bit_idle])
        else $error("idle not latched");

    // Status clearing; a set in the clearing cycle wins
    events_all_a: assert property (@(posedge clock) disable iff (!rst_sync) // [RULE_09]
        |events
        |=> (status & $past(events)) == $past(events))
        else $error("simultaneous event lost");

    status_hold_a: assert property (@(posedge clock) disable iff (!rst_sync) // [RULE_09]
        !rd_status && !wr_clear
        |=> (status & $past(status)) == $past(status))
        else $error("status bit dropped");

    clear_bits_a: assert property (@(posedge clock) disable iff (!rst_sync) // [RULE_09]
        wr_clear
        |=> (status & $past(wdata[6:0]) & ~$past(events)) == 7'h00)
        else $error("clear did not clear");

    clear_keep_a: assert property (@(posedge clock) disable iff (!rst_sync) // [RULE_09]
        wr_clear && !(|events)
        |=> status == ($past(status) & ~$past(wdata[6:0])))
        else $error("clear touched other bits");

    read_set_wins_a: assert property (@(posedge clock) disable iff (!rst_sync) // [RULE_09]
        rd_status && (|events)
        |=> status == $past(events))
        else $error("read lost new event");

    no_spurious_a: assert property (@(posedge clock) disable iff (!rst_sync) // [RULE_09]
        !(|events)
        |=> (status & ~$past(status)) == 7'h00)
        else $error("status set without event");

    // Register port
    rdata_idle_a: assert property (@(posedge clock) disable iff (!rst_sync) // [RULE_08]
        !rd
        |=> rdata == 8'h00)
        else $error("read data not zero");

    rdata_enable_a: assert property (@(posedge clock) disable iff (!rst_sync) // [RULE_08]
        rd && (addr == dlie_pkg::enable_offset)
        |=> rdata == {1'b0, $past(data_link_event_irq_enable)})
        else $error("enable read wrong");

    rdata_status_a: assert property (@(posedge clock) disable iff (!rst_sync) // [RULE_09]
        rd_status
        |=> rdata == {1'b0, $past(status)})
        else $error("status read wrong");

    rdata_whole_a: assert property (@(posedge clock) disable iff (!rst_sync) // [RULE_10]
        rd && (addr == dlie_pkg::whole_offset)
        |=> rdata == {7'h00, $past(whole_sticky)})
        else $error("whole read wrong");

    rdata_unmapped_a: assert property (@(posedge clock) disable iff (!rst_sync) // [RULE_08]
        rd && (addr != dlie_pkg::enable_offset) && (addr != dlie_pkg::status_offset)
        && (addr != dlie_pkg::whole_offset) |=> rdata == 8'h00)
        else $error("unmapped read not zero");

    status_bit7_a: assert property (@(posedge clock) disable iff (!rst_sync) // [RULE_11]
        rd_status
        |=> !rdata[7])
        else $error("status bit 7 not zero");

    enable_hold_a: assert property (@(posedge clock) disable iff (!rst_sync) // [RULE_08]
        !wr_enable
        |=> $stable(data_link_event_irq_enable))
        else $error("enable changed");

    // Interrupt request
    irq_masked_a: assert property (@(posedge clock) disable iff (!rst_sync) // [RULE_11]
        data_link_event_irq_enable == 7'h00 && !wr_enable
        |=> !irq)
        else $error("irq while all masked");

    irq_quiet_a: assert property (@(posedge clock) disable iff (!rst_sync) // [RULE_11]
        status == 7'h00
        |-> !irq)
        else $error("irq with empty status");

    irq_low_a: assert property (@(posedge clock) disable iff (!rst_sync) // [RULE_11]
        !wr_enable && (((status | events) & data_link_event_irq_enable) == 7'h00)
        |=> !irq)
        else $error("irq without cause");

    irq_rise_a: assert property (@(posedge clock) disable iff (!rst_sync) // [RULE_11]
        $rose(irq)
        |-> $past((|events) || wr_enable))
        else $error("irq rose without cause");

    irq_new_enable_a: assert property (@(posedge clock) disable iff (!rst_sync) // [RULE_11]
        wr_enable
        |=> irq == |(status & $past(wdata[6:0])))
        else $error("irq ignored new enable");

    // Whole-message indication
    whole_source_a: assert property (@(posedge clock) disable iff (!rst_sync) // [RULE_10]
        rx_whole_msg
        |-> $past(rx_flag_idle && rx_msg_done))
        else $error("whole pulse without cause");

    whole_none_a: assert property (@(posedge clock) disable iff (!rst_sync) // [RULE_10]
        !(rx_flag_idle && rx_msg_done)
        |=> !rx_whole_msg)
        else $error("whole pulse too long");

    whole_hold_a: assert property (@(posedge clock) disable iff (!rst_sync) // [RULE_10]
        whole_sticky && !(rd && (addr == dlie_pkg::whole_offset))
        |=> whole_sticky)
        else $error("whole sticky dropped");

    whole_clear_a: assert property (@(posedge clock) disable iff (!rst_sync) // [RULE_10]
        rd && (addr == dlie_pkg::whole_offset) && !(rx_flag_idle && rx_msg_done)
        |=> !whole_sticky)
        else $error("whole sticky not cleared");

    // Reset checks run without disable so they see the release itself
    reset_outputs_a: assert property (@(posedge clock) // [RULE_08]
        $rose(rst_sync)
        |-> !irq && (rdata == 8'h00) && !rx_whole_msg && (status == 7'h00))
        else $error("outputs not clear after reset");

    reset_hold_a: assert property (@(posedge clock) // [RULE_08]
        !rstn
        |-> !rst_sync)
        else $error("internal reset not held");

    reset_release_a: assert property (@(posedge clock) // [RULE_08]
        $rose(rstn)
        |-> !rst_sync ##1 !rst_sync ##1 rst_sync)
        else $error("reset release timing wrong");

    irq_seen_c: cover property (@(posedge clock) disable iff (!rst_sync) $rose(irq));
    read_clr_c: cover property (@(posedge clock) disable iff (!rst_sync)
        irq ##1 rd_status ##1 !irq);
    set_wins_c: cover property (@(posedge clock) disable iff (!rst_sync)
        rd_status && rx_abort_seen);
    whole_c:    cover property (@(posedge clock) disable iff (!rst_sync) rx_whole_msg);
    clear_c:    cover property (@(posedge clock) disable iff (!rst_sync)
        wr_clear && (|status));
endmodule : dlie_top

// ==== tb_dlie_top.sv ====
// Self-checking testbench for the data link event interrupt block
`timescale 1ns/100ps
module tb_dlie_top;
    logic        clock;
    logic        rstn;
    logic [15:0] addr;
    logic [7:0]  wdata;
    logic        wr;
    logic        rd;
    logic [7:0]  rdata;
    logic [6:0]  ev;
    logic        irq;
    logic        rx_whole_msg;
    logic [7:0]  d;
    int          n_fail;
    int          checked;
    int          cycles;

    dlie_top u_dlie_top (.clock(clock), .rstn(rstn), .addr(addr), .wdata(wdata), .wr(wr),
        .rd(rd), .rdata(rdata), .tx_msg_begin(ev[6]), .rx_msg_begin(ev[5]),
        .tx_msg_done(ev[4]), .rx_msg_done(ev[3]), .check_seq_error(ev[2]),
        .rx_abort_seen(ev[1]), .rx_flag_idle(ev[0]), .irq(irq), .rx_whole_msg(rx_whole_msg));

    initial begin
        clock = 1'b0;
        forever #50 clock = ~clock;
    end

    // Whole run needs well under 1000 cycles; the ceiling only catches a hang
    always @(posedge clock) begin
        cycles++;
        if (cycles == 3000) begin
            n_fail++;
            end_of_test();
        end
    end

    task automatic end_of_test;
        if (n_fail == 0 && checked > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : end_of_test

    task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
        checked++;
        if (got !== exp) begin
            n_fail++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask : check

    task automatic reg_write(input logic [15:0] a, input logic [7:0] v);
        @(posedge clock);
        addr  <= a;
        wdata <= v;
        wr    <= 1'b1;
        @(posedge clock);
        wr    <= 1'b0;
        #1;
    endtask : reg_write

    // Read data stand only in the cycle after the strobe, so sample just past that edge
    task automatic reg_read(input logic [15:0] a, output logic [7:0] v);
        @(posedge clock);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clock);
        rd   <= 1'b0;
        #1 v = rdata;
    endtask : reg_read

    task automatic pulse(input logic [6:0] v);
        @(posedge clock);
        ev <= v;
        @(posedge clock);
        ev <= 7'h00;
        #1;
    endtask : pulse

    task automatic t_enable_rw;
        reg_read(dlie_pkg::enable_offset, d);
        check("enable after reset", 8'h00, d);
        check("irq after reset", 8'h00, {7'h00, irq});
        reg_write(dlie_pkg::enable_offset, 8'hff);
        reg_read(dlie_pkg::enable_offset, d);
        check("enable top bit", 8'h7f, d);
        reg_write(dlie_pkg::enable_offset, 8'h2a);
        reg_write(16'h0b08, 8'h55);
        reg_read(dlie_pkg::enable_offset, d);
        check("enable kept", 8'h2a, d);
        reg_read(16'h0b08, d);
        check("unmapped read", 8'h00, d);
    endtask : t_enable_rw

    // Event latched while masked must raise irq as soon as its enable is set
    task automatic t_events;
        logic [6:0] m;
        for (int i = 0; i < dlie_pkg::event_count; i++) begin
            m = 7'h01 << i;
            reg_write(dlie_pkg::enable_offset, {1'b0, ~m});
            pulse(m);
            check("irq masked", 8'h00, {7'h00, irq});
            reg_write(dlie_pkg::enable_offset, {1'b0, m});
            check("irq enabled", 8'h01, {7'h00, irq});
            reg_read(dlie_pkg::status_offset, d);
            check("status", {1'b0, m}, d);
            check("irq after read", 8'h00, {7'h00, irq});
        end
    endtask : t_events

    task automatic t_clear;
        reg_write(dlie_pkg::enable_offset, 8'h7f);
        pulse(7'h06);
        check("irq two events", 8'h01, {7'h00, irq});
        reg_write(dlie_pkg::clear_offset, 8'h02);
        reg_read(dlie_pkg::status_offset, d);
        check("status after clear", 8'h04, d);
        reg_read(dlie_pkg::status_offset, d);
        check("status second read", 8'h00, d);
    endtask : t_clear

    task automatic t_whole;
        pulse(7'h01);
        check("whole idle alone", 8'h00, {7'h00, rx_whole_msg});
        pulse(7'h09);
        check("whole pulse", 8'h01, {7'h00, rx_whole_msg});
        @(posedge clock);
        #1 check("whole pulse end", 8'h00, {7'h00, rx_whole_msg});
        reg_read(dlie_pkg::whole_offset, d);
        check("whole sticky", 8'h01, d);
        reg_read(dlie_pkg::whole_offset, d);
        check("whole cleared", 8'h00, d);
        reg_read(dlie_pkg::status_offset, d);
        check("status idle and done", 8'h09, d);
    endtask : t_whole

    // A read that clears status must not lose an event of the same cycle
    task automatic t_set_wins;
        pulse(7'h02);
        @(posedge clock);
        addr <= dlie_pkg::status_offset;
        rd   <= 1'b1;
        ev   <= 7'h40;
        @(posedge clock);
        rd   <= 1'b0;
        ev   <= 7'h00;
        #1 d = rdata;
        check("status with event", 8'h02, d);
        check("irq kept by event", 8'h01, {7'h00, irq});
        reg_read(dlie_pkg::status_offset, d);
        check("event survived read", 8'h40, d);
    endtask : t_set_wins

    initial begin
        rstn  = 1'b0;
        addr  = 16'h0000;
        wdata = 8'h00;
        wr    = 1'b0;
        rd    = 1'b0;
        ev    = 7'h00;
        repeat (6) @(posedge clock);
        rstn <= 1'b1;
        repeat (3) @(posedge clock);
        t_enable_rw();
        t_events();
        t_clear();
        t_whole();
        t_set_wins();
        end_of_test();
    end
endmodule : tb_dlie_top
